// ### test/adc_config_reg_and_test_mode_tb_top.sv
`default_nettype none
module adc_config_reg_and_test_mode_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       cv = 1'b0;
	logic [9:0] raw_r = 10'h0;
	logic       cs_n, cs_hi, rd_n, wr_n, oe, data_oe, dev_rst, fmt, rv, izero, lo, hi, sync;
	logic [11:0] din;
	logic [9:0] dout, sz;
	int         error_cnt = 0;
	int         n_tests = 0;
	always #10 clk = ~clk;
	host_bus_model u_host_bus_model (.clk(clk), .oe(data_oe), .cs_n(cs_n), .cs_hi(cs_hi),
		.rd_n(rd_n), .wr_n(wr_n), .dout(din));
	adc_config_top u_adc_config_top (.CORE_CLK(clk), .RESETN(resetn),
		.SELECT_LOW_ACTIVE_N(cs_n), .SELECT_HIGH_ACTIVE(cs_hi), .RD_N(rd_n), .WR_N(wr_n),
		.DATA_IN(din), .DATA_OUT(dout), .DATA_OE(data_oe), .CONV_VALID(cv),
		.CONV_RESULT(raw_r), .CHECK_SEL_LO(lo), .CHECK_SEL_HI(hi), .SETUP_ZERO(sz),
		.INPUT_ZERO(izero), .SYNC_GEN_CLEAR(sync), .DEVICE_RESET(dev_rst),
		.NUMBER_FORMAT_SELECT(fmt), .RESULT_VALID(rv));
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conv(input logic [9:0] raw);
		@(posedge clk) #1;
		cv = 1'b1;
		raw_r = raw;
		@(posedge clk) #1;
		cv = 1'b0;
		raw_r = ~raw;
		@(posedge clk);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1 resetn = 1'b1;
		chk("setup zero", 12'(sz), 12'(adc_cfg_pkg::SETUP_ZERO_RST));
		chk("format", 12'(fmt), 12'h0);
		u_host_bus_model.read(1'b0, 1'b1, oe);
		chk("read enable", 12'(oe), 12'h1);
		$display("reset test done");
		for (int c = 0; c < 4; c++)
		begin
			u_host_bus_model.write({2'h0, c[1:0], 8'h20}, 1'b1);
			chk("check select", 12'({hi, lo}), 12'(c));
		end
		u_host_bus_model.write(12'h8ff, 1'b1);
		chk("unmapped", 12'(sz), 12'h320);
		u_host_bus_model.write(12'h0ff, 1'b0);
		chk("deselected", 12'(sz), 12'h320);
		$display("register test done");
		conv(10'h005);
		chk("result", 12'(dout), 12'h005);
		u_host_bus_model.write(12'h4b0, 1'b1);
		chk("format", 12'(fmt), 12'h1);
		conv(10'h005);
		chk("offset binary", 12'(dout), 12'h205);
		// Calibration with sync clear set, as a multichannel setup does
		u_host_bus_model.write(12'h532, 1'b1);
		chk("inputs zeroed", 12'(izero), 12'h1);
		conv(10'h003);
		chk("cal done", 12'(izero), 12'h0);
		conv(10'h010);
		chk("corrected", 12'(dout), 12'h00d);
		conv(10'h001);
		chk("wrapped", 12'(dout), 12'h3fe);
		$display("conversion test done");
		u_host_bus_model.write(12'h470, 1'b1);
		u_host_bus_model.read(1'b1, 1'b1, oe);
		chk("combined read", 12'(oe), 12'h1);
		u_host_bus_model.write(12'h100, 1'b1);
		chk("combined write", 12'({hi, lo}), 12'h1);
		u_host_bus_model.write(12'h431, 1'b1);
		chk("soft reset", 12'(dev_rst), 12'h1);
		chk("setup zero", 12'(sz), 12'h020);
		u_host_bus_model.write(12'h300, 1'b1);
		chk("held", 12'(sz), 12'h020);
		u_host_bus_model.write(12'h430, 1'b1);
		chk("released", 12'(dev_rst), 12'h0);
		u_host_bus_model.read(1'b1, 1'b1, oe);
		chk("separate strobes", 12'(oe), 12'h0);
		conv(10'h010);
		chk("offset cleared", 12'(dout), 12'h010);
		$display("mode test done");
		results;
	end
	initial
	begin
		#100000;
		error_cnt++;
		results;
	end
endmodule
`default_nettype wire

// ### test/adc_config_sva.sv
`default_nettype none
module adc_config_sva (
	input wire logic        CORE_CLK, RESETN, SELECT_LOW_ACTIVE_N, SELECT_HIGH_ACTIVE,
	input wire logic        RD_N, WR_N, DATA_OE, CONV_VALID, CHECK_SEL_LO, CHECK_SEL_HI,
	input wire logic        INPUT_ZERO, SYNC_GEN_CLEAR, DEVICE_RESET, RESULT_VALID,
	input wire logic        NUMBER_FORMAT_SELECT,
	input wire logic [11:0] DATA_IN
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	wire sel = !SELECT_LOW_ACTIVE_N && SELECT_HIGH_ACTIVE;
	wire wr  = sel && !WR_N && RD_N;
	// Leading edge of a write outside soft reset
	sequence take(a);
		$rose(wr) && DATA_IN[11:10] == a && !DEVICE_RESET;
	endsequence
	sequence two_cmd(b);
		take(2'h1) ##0 (DATA_IN[b] && !DATA_IN[0]);
	endsequence
	read_enable_a: assert property (sel && !RD_N && WR_N |-> DATA_OE)
		else $error("read strobe without output enable");
	deselect_quiet_a: assert property (!sel |-> !DATA_OE)
		else $error("output enable while deselected");
	check_select_a: assert property (take(2'h0) |=>
		{CHECK_SEL_HI, CHECK_SEL_LO} == $past(DATA_IN[9:8])) else $error("check select wrong");
	sync_pulse_a: assert property (two_cmd(1) |=> SYNC_GEN_CLEAR ##1 !SYNC_GEN_CLEAR)
		else $error("sync clear pulse wrong");
	soft_reset_a: assert property (take(2'h1) ##0 DATA_IN[0] |=>
		DEVICE_RESET && !CHECK_SEL_HI && !CHECK_SEL_LO) else $error("soft reset not entered");
	reset_hold_a: assert property (DEVICE_RESET && !$rose(wr) |=> DEVICE_RESET)
		else $error("soft reset left without write");
	format_bit_a: assert property (take(2'h1) ##0 !DATA_IN[0] |=>
		NUMBER_FORMAT_SELECT == $past(DATA_IN[7])) else $error("format bit wrong");
	cal_start_a: assert property (two_cmd(8) |=> INPUT_ZERO)
		else $error("calibration not started");
	cal_end_a: assert property (INPUT_ZERO && CONV_VALID |=> !INPUT_ZERO && !RESULT_VALID)
		else $error("calibration end wrong");
	result_cause_a: assert property (RESULT_VALID |-> $past(CONV_VALID) && !$past(DEVICE_RESET))
		else $error("result without conversion");
endmodule

bind adc_config_top adc_config_sva u_adc_config_sva (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
	.SELECT_LOW_ACTIVE_N(SELECT_LOW_ACTIVE_N), .SELECT_HIGH_ACTIVE(SELECT_HIGH_ACTIVE),
	.RD_N(RD_N), .WR_N(WR_N), .DATA_OE(DATA_OE), .CONV_VALID(CONV_VALID),
	.CHECK_SEL_LO(CHECK_SEL_LO), .CHECK_SEL_HI(CHECK_SEL_HI), .INPUT_ZERO(INPUT_ZERO),
	.SYNC_GEN_CLEAR(SYNC_GEN_CLEAR), .DEVICE_RESET(DEVICE_RESET), .RESULT_VALID(RESULT_VALID),
	.NUMBER_FORMAT_SELECT(NUMBER_FORMAT_SELECT), .DATA_IN(DATA_IN));
`default_nettype wire

// ### test/host_bus_model.sv
`default_nettype none
module host_bus_model (
	input  wire logic   clk,   // Core clock
	input  wire logic   oe,    // Device output enable
	output logic        cs_n,  // Chip select, low
	output logic        cs_hi, // Chip select, high
	output logic        rd_n,  // Read strobe
	output logic        wr_n,  // Write strobe or R/W
	output logic [11:0] dout   // Word to device
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{cs_n, cs_hi, rd_n, wr_n} = 4'hb;
		dout = 12'h0;
	end
	// Caller gives the whole word and the high select level; released bus shows inverse
	task automatic write(input logic [11:0] w, input logic hi);
		@(posedge clk) #1;
		dout = w;
		{cs_n, cs_hi, rd_n, wr_n} = {1'b0, hi, 2'b10};
		repeat (2) @(posedge clk);
		#1 {cs_n, cs_hi, wr_n} = 3'b101;
		dout = ~w;
		@(posedge clk);
	endtask
	// In combined mode the read pin is left high
	task automatic read(input logic r, input logic w, output logic seen);
		@(posedge clk) #1;
		{cs_n, cs_hi, rd_n, wr_n} = {2'b01, r, w};
		@(posedge clk);
		seen = oe;
		#1 {cs_n, cs_hi, rd_n, wr_n} = 4'hb;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ### verilog/adc_cfg_pkg.sv
`default_nettype none

package adc_cfg_pkg;

	localparam int DATA_W = 10;
	localparam int WORD_W = 12;

	// Register select code in word bits 11:10
	localparam logic [1:0] ADDR_SETUP_ZERO = 2'h0;
	localparam logic [1:0] ADDR_SETUP_TWO  = 2'h1;
	localparam int         ADDR_MSB        = 11;
	localparam int         ADDR_LSB        = 10;

	localparam logic [9:0]  SETUP_ZERO_RST = 10'h020;
	localparam logic [11:0] SETUP_TWO_RST  = 12'h430;

	// Converter check voltage selection
	typedef enum logic [1:0] {
		CHECK_NORMAL  = 2'h0,
		CHECK_POS_REF = 2'h1,
		CHECK_MID_REF = 2'h2,
		CHECK_NEG_REF = 2'h3
	} check_t;

	typedef struct packed {
		check_t     check_sel;
		logic       scan;
		logic [1:0] diff;
		logic [1:0] chan_sel;
		logic       power_down;
		logic       rsv1;
		logic       ext_ref;
	} setup_zero_t;

	typedef struct packed {
		logic [1:0] addr;
		logic       rsv9;
		logic       offset_cal;
		logic       number_format_select;
		logic       strobe_mode;
		logic [3:0] rsv5_2;
		logic       sync_gen_clear;
		logic       soft_reset;
	} setup_two_t;

	typedef struct packed {
		logic select_low_active_n;
		logic select_high_active;
		logic rd_n;
		logic wr_n;
	} strobe_pins_t;

	// Offset calibration sequencer
	typedef enum logic [1:0] {
		CAL_IDLE = 2'h0,
		CAL_ZERO = 2'h1
	} cal_state_t;

endpackage

`default_nettype wire

// ### verilog/adc_config_top.sv
`default_nettype none

module adc_config_top #(
	parameter int DATA_W = adc_cfg_pkg::DATA_W
) (
	input  wire logic                       CORE_CLK,             // 50 MHz clock
	input  wire logic                       RESETN,               // Async reset, low
	input  wire logic                       SELECT_LOW_ACTIVE_N,  // Chip select, low
	input  wire logic                       SELECT_HIGH_ACTIVE,   // Chip select, high
	input  wire logic                       RD_N,                 // Read strobe, low
	input  wire logic                       WR_N,                 // Write strobe or R/W
	input  wire logic [adc_cfg_pkg::WORD_W-1:0] DATA_IN,          // Written word
	output logic      [DATA_W-1:0]          DATA_OUT,             // Result to host
	output logic                            DATA_OE,              // Drives data bus
	input  wire logic                       CONV_VALID,           // Raw result strobe
	input  wire logic [DATA_W-1:0]          CONV_RESULT,          // Raw two's complement
	output logic                            CHECK_SEL_LO,         // Check select bit 0
	output logic                            CHECK_SEL_HI,         // Check select bit 1
	output logic      [9:0]                 SETUP_ZERO,           // Setup-zero contents
	output logic                            INPUT_ZERO,           // Inputs forced to 0
	output logic                            SYNC_GEN_CLEAR,       // Sync generator reset
	output logic                            DEVICE_RESET,         // Soft reset level
	output logic                            NUMBER_FORMAT_SELECT, // 1: offset binary
	output logic                            RESULT_VALID          // New result pulse
);

	adc_cfg_pkg::setup_zero_t  setup0_r;
	adc_cfg_pkg::setup_two_t   setup1_r;
	adc_cfg_pkg::setup_two_t   wr_word;
	adc_cfg_pkg::strobe_pins_t pins;
	adc_cfg_pkg::cal_state_t   cal_r;
	adc_cfg_pkg::cal_state_t   cal_nxt;
	logic [DATA_W-1:0]         offset_r;
	logic [DATA_W-1:0]         result_r;
	logic [DATA_W-1:0]         corrected;
	logic                      sync_clr_r;
	logic                      valid_r;
	logic                      rd_act;
	logic                      wr_pulse;
	logic                      wr_setup0;
	logic                      wr_setup1;
	logic                      in_reset;
	logic                      reset_now;
	logic                      cmd_ok;
	logic                      take_result;

	// Register select of a written word, from its top two bits
	function automatic logic addr_hit(
		input adc_cfg_pkg::setup_two_t word,
		input logic [1:0]              code
	);
		return word.addr == code;
	endfunction

	// Offset binary is two's complement with the sign bit inverted
	function automatic logic [DATA_W-1:0] to_output(
		input logic [DATA_W-1:0] value,
		input logic              offset_bin
	);
		return offset_bin ? {~value[DATA_W-1], value[DATA_W-2:0]} : value;
	endfunction

	// Host pins gathered into one carrier for the strobe decoder
	assign pins.select_low_active_n = SELECT_LOW_ACTIVE_N;
	assign pins.select_high_active  = SELECT_HIGH_ACTIVE;
	assign pins.rd_n                = RD_N;
	assign pins.wr_n                = WR_N;

	// Writes are taken on the strobe's leading edge, so a held strobe loads once
	host_strobe_decode u_strobe (
		.clk      (CORE_CLK),
		.rst_n    (RESETN),
		.pins     (pins),
		.combined (setup1_r.strobe_mode),
		.rd_act   (rd_act),
		.wr_act   (),
		.wr_pulse (wr_pulse)
	);

	assign wr_word   = adc_cfg_pkg::setup_two_t'(DATA_IN);
	assign in_reset  = setup1_r.soft_reset;
	assign wr_setup0 = wr_pulse && addr_hit(wr_word, adc_cfg_pkg::ADDR_SETUP_ZERO);
	assign wr_setup1 = wr_pulse && addr_hit(wr_word, adc_cfg_pkg::ADDR_SETUP_TWO);
	// Entering soft reset takes effect at the very edge that loads the word
	assign reset_now = in_reset || (wr_setup1 && wr_word.soft_reset);
	// Command bits act only on words taken outside soft reset
	assign cmd_ok    = wr_setup1 && !wr_word.soft_reset && !in_reset;
	// Results during calibration become the offset and are not shown
	assign take_result = CONV_VALID && (cal_r == adc_cfg_pkg::CAL_IDLE) && !in_reset;

	// Setup-zero: held at reset value while soft reset is set
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			setup0_r <= adc_cfg_pkg::SETUP_ZERO_RST;
		else if (reset_now)
			setup0_r <= adc_cfg_pkg::SETUP_ZERO_RST;
		else if (wr_setup0)
			setup0_r <= adc_cfg_pkg::setup_zero_t'(DATA_IN[9:0]);
	end

	// Setup-two: only soft reset bit is honoured while in reset
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			setup1_r <= adc_cfg_pkg::SETUP_TWO_RST;
		else if (wr_setup1)
		begin
			// The reset bit itself is kept, so the device stays in reset
			if (wr_word.soft_reset)
			begin
				setup1_r            <= adc_cfg_pkg::SETUP_TWO_RST;
				setup1_r.soft_reset <= 1'b1;
			end
			// In reset, a word with the reset bit clear only ends reset
			else if (in_reset)
				setup1_r <= adc_cfg_pkg::SETUP_TWO_RST;
			else
				setup1_r <= wr_word;
		end
	end

	// Sync generator clear: one-cycle pulse per accepted setup-two write with the sync clear bit set
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			sync_clr_r <= 1'b0;
		else
			sync_clr_r <= cmd_ok && wr_word.sync_gen_clear;
	end

	// Offset calibration sequencer
	always_comb
	begin
		cal_nxt = cal_r;
		unique case (cal_r)
			adc_cfg_pkg::CAL_IDLE:
			begin
				if (cmd_ok && wr_word.offset_cal)
					cal_nxt = adc_cfg_pkg::CAL_ZERO;
			end
			adc_cfg_pkg::CAL_ZERO:
			begin
				if (CONV_VALID)
					cal_nxt = adc_cfg_pkg::CAL_IDLE;
			end
			default:
				cal_nxt = adc_cfg_pkg::CAL_IDLE;
		endcase
	end

	// Soft reset aborts a calibration in progress
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			cal_r <= adc_cfg_pkg::CAL_IDLE;
		else if (in_reset)
			cal_r <= adc_cfg_pkg::CAL_IDLE;
		else
			cal_r <= cal_nxt;
	end

	// Stored offset, cleared by soft reset
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			offset_r <= '0;
		else if (in_reset)
			offset_r <= '0;
		else if (cal_r == adc_cfg_pkg::CAL_ZERO && CONV_VALID)
			offset_r <= CONV_RESULT;
	end

	// Difference wraps modulo the result width
	assign corrected = DATA_W'(CONV_RESULT - offset_r);

	// Result strobe: one pulse per result handed to the host
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			valid_r <= 1'b0;
		else
			valid_r <= take_result;
	end

	// Output result register with number format applied
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			result_r <= '0;
		else if (take_result)
			result_r <= to_output(corrected, setup1_r.number_format_select);
	end

	// Setup-two is write-only: reads return only results
	assign DATA_OUT             = result_r;
	assign DATA_OE              = rd_act;
	assign CHECK_SEL_LO         = setup0_r.check_sel[0];
	assign CHECK_SEL_HI         = setup0_r.check_sel[1];
	assign SETUP_ZERO           = setup0_r;
	assign INPUT_ZERO           = (cal_r == adc_cfg_pkg::CAL_ZERO);
	assign SYNC_GEN_CLEAR       = sync_clr_r;
	assign DEVICE_RESET         = in_reset;
	assign NUMBER_FORMAT_SELECT = setup1_r.number_format_select;
	assign RESULT_VALID         = valid_r;

endmodule

`default_nettype wire

// ### verilog/host_strobe_decode.sv
`default_nettype none

module host_strobe_decode (
	input  wire logic                      clk,        // Core clock
	input  wire logic                      rst_n,      // Async reset, low
	input  wire adc_cfg_pkg::strobe_pins_t pins,       // Selects and strobes
	input  wire logic                      combined,   // 1: write pin is R/W
	output logic                           rd_act,     // Internal read strobe
	output logic                           wr_act,     // Internal write strobe
	output logic                           wr_pulse    // First cycle of write
);

	logic sel;
	logic wr_act_r;

	assign sel = !pins.select_low_active_n && pins.select_high_active;

	always_comb
	begin
		if (combined)
		begin
			rd_act = sel && pins.wr_n;
			wr_act = sel && !pins.wr_n;
		end
		else
		begin
			rd_act = sel && !pins.rd_n && pins.wr_n;
			wr_act = sel && !pins.wr_n && pins.rd_n;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			wr_act_r <= 1'b0;
		else
			wr_act_r <= wr_act;
	end

	assign wr_pulse = wr_act && !wr_act_r;

endmodule

`default_nettype wire
